// [rxl_lane_ram.sv]
`default_nettype none
module rxl_lane_ram #(
  parameter int W = 32,
  parameter int DEPTH = 64,
  localparam int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  // Read side
  input wire logic [AW-1:0] rdAddr,
  output logic [W-1:0] rdData
);
  logic [W-1:0] mem [DEPTH];

  // Write port, no reset on the array
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read keeps the output off the array path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : rxl_lane_ram
`default_nettype wire

// [rxl_pkg.sv]
`default_nettype none
package rxl_pkg;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SHIFT = 8'h04;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_FRAME = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FILL0 = 8'h40;
  localparam int REG_STRIDE = 4;
  localparam int CTRL_CORE_RST = 0;
  localparam int CTRL_ERR_DIS = 1;
  localparam int FRM_K_LSB = 8;
  localparam int ST_RELEASED = 0;
  localparam int ST_SYNC = 1;
  localparam int ST_ALL_VALID = 2;
  localparam int ST_REINIT = 3;
  localparam logic [1:0] CTRL_RST_VAL = 2'h0;
  localparam logic [7:0] SHIFT_RST_VAL = 8'h00;
  localparam logic [9:0] TRIM_RST_VAL = 10'h000;
  localparam logic [7:0] FRM_F_RST_VAL = 8'h02;
  localparam logic [4:0] FRM_K_RST_VAL = 5'h10;

  // ----------------------------------------------------------
  // Link constants
  // ----------------------------------------------------------
  localparam int OCT_PER_CYC = 4;
  localparam int OCT_SHIFT = 2;
  localparam int LANE_W = 32;
  localparam int FILL_W = 10;
  localparam logic [3:0] ALL_OCT = 4'hf;
  localparam logic [3:0] LIM_DEC = 4'h4;
  localparam logic [3:0] LIM_CTL = 4'h4;
  localparam logic [3:0] LIM_ALN = 4'h8;
  localparam logic [7:0] CHAR_MF_END = 8'h7c;
  localparam int MINOR_FRAMES = 2;
  localparam int REINIT_FRAMES = 16;

  // One lane as delivered by the decoder
  typedef struct packed {
    logic valid;
    logic [LANE_W-1:0] data;
    logic [OCT_PER_CYC-1:0] isK;
    logic [OCT_PER_CYC-1:0] dispErr;
    logic [OCT_PER_CYC-1:0] notInTable;
  } rxl_lane_type;

  // Modular counter step
  function automatic logic [7:0] rxl_wrap(input logic [7:0] v, input logic [7:0] last);
    return (v == last) ? 8'h00 : v + 8'h01;
  endfunction : rxl_wrap

  // Saturating error count
  function automatic logic [3:0] rxl_sat(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction : rxl_sat
endpackage : rxl_pkg
`default_nettype wire

// [rxl_rx_latency.sv]
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`default_nettype none
module rxl_rx_latency import rxl_pkg::*; #(
  parameter int LANES = 2,
  parameter int BUF_DEPTH = 64,
  parameter int MF_MAX = 256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Link side
  input wire logic sysref,
  input wire rxl_lane_type laneIn [LANES],
  output logic syncN,
  // Aligned output stream
  output logic [LANES*LANE_W-1:0] outData,
  output logic outValid
);
  localparam int AW = $clog2(BUF_DEPTH);

  // ----------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------
  if (LANES < 1 || LANES > 8) begin : g_badLanes
    $error("LANES must be 1 to 8");
  end
  // Buffer must hold a full multiframe, pointers wrap cleanly
  if (BUF_DEPTH * OCT_PER_CYC < MF_MAX || (1 << AW) != BUF_DEPTH
      || AW + OCT_SHIFT > FILL_W) begin : g_badDepth
    $error("BUF_DEPTH cannot serve MF_MAX");
  end

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  logic ackR;
  logic wrTake;
  logic [1:0] ctrlR;
  logic [7:0] shiftR;
  logic [9:0] trimR;
  logic [7:0] frmFR;
  logic [4:0] frmKR;
  logic [31:0] rdMux;
  logic coreRst;
  logic [FILL_W-1:0] fillR [LANES];
  logic relR;
  logic allValid;
  logic anyReinit;
  logic repSyncN;
  logic longActive;

  // One wait state per access; answer on the second edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackR <= 1'b0;
    end else begin
      ackR <= (read || write) && !ackR;
    end
  end
  assign waitrequest = (read || write) && !ackR;
  assign wrTake = write && ackR;
  assign coreRst = ctrlR[CTRL_CORE_RST];

  // Software writes; unmapped writes are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlR <= CTRL_RST_VAL;
      shiftR <= SHIFT_RST_VAL;
      trimR <= TRIM_RST_VAL;
      frmFR <= FRM_F_RST_VAL;
      frmKR <= FRM_K_RST_VAL;
    end else if (wrTake) begin
      case (address)
        ADDR_CTRL: ctrlR <= writedata[1:0];
        ADDR_SHIFT: shiftR <= writedata[7:0];
        ADDR_TRIM: trimR <= writedata[9:0];
        ADDR_FRAME: begin
          frmFR <= writedata[7:0];
          frmKR <= writedata[FRM_K_LSB+:5];
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (address)
      ADDR_CTRL: rdMux = 32'(ctrlR);
      ADDR_SHIFT: rdMux = 32'(shiftR);
      ADDR_TRIM: rdMux = 32'(trimR);
      ADDR_FRAME: rdMux = {19'h0, frmKR, frmFR};
      ADDR_STATUS: begin
        rdMux = '0;
        rdMux[ST_RELEASED] = relR;
        rdMux[ST_SYNC] = syncN;
        rdMux[ST_ALL_VALID] = allValid;
        rdMux[ST_REINIT] = longActive;
      end
      default: rdMux = '0;
    endcase
    for (int i = 0; i < LANES; i++) begin
      if (address == ADDR_FILL0 + 8'(i * REG_STRIDE)) begin
        rdMux = 32'(fillR[i]);
      end
    end
  end

  // Read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= '0;
    end else if (read && !ackR) begin
      readdata <= rdMux;
    end
  end

  // ----------------------------------------------------------
  // Active configuration
  // ----------------------------------------------------------
  logic [7:0] actShift;
  logic [9:0] actTrim;
  logic [7:0] actF;
  logic [4:0] actK;
  logic [10:0] mfCycles;
  logic [10:0] trimCyc;
  logic [10:0] relIdx;

  // Settings only move while the core is held in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      actShift <= SHIFT_RST_VAL;
      actTrim <= TRIM_RST_VAL;
      actF <= FRM_F_RST_VAL;
      actK <= FRM_K_RST_VAL;
    end else if (coreRst) begin
      actShift <= shiftR;
      actTrim <= trimR;
      actF <= frmFR;
      actK <= frmKR;
    end
  end

  assign mfCycles = 11'((int'(actF) * int'(actK)) / OCT_PER_CYC);
  assign trimCyc = 11'(actTrim >> OCT_SHIFT);
  // Trim moves the release point back from the boundary
  assign relIdx = (trimCyc == '0) ? '0 : mfCycles - trimCyc;

  // ----------------------------------------------------------
  // Local multiframe clock
  // ----------------------------------------------------------
  logic lmfcRun;
  logic dlyAct;
  logic [7:0] dlyCnt;
  logic [10:0] lmfcIdx;

  // First SYSREF after core reset starts the delay, later ones ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lmfcRun <= 1'b0;
      dlyAct <= 1'b0;
      dlyCnt <= '0;
      lmfcIdx <= '0;
    end else if (coreRst) begin
      lmfcRun <= 1'b0;
      dlyAct <= 1'b0;
      dlyCnt <= '0;
      lmfcIdx <= '0;
    end else if (lmfcRun) begin
      lmfcIdx <= (lmfcIdx == mfCycles - 11'h001) ? '0 : lmfcIdx + 11'h001;
    end else if (dlyAct) begin
      if (dlyCnt == '0) begin
        lmfcRun <= 1'b1;
        lmfcIdx <= '0;
        dlyAct <= 1'b0;
      end else begin
        dlyCnt <= dlyCnt - 8'h01;
      end
    end else if (sysref) begin
      dlyAct <= 1'b1;
      dlyCnt <= actShift;
    end
  end

  // ----------------------------------------------------------
  // Release and read side
  // ----------------------------------------------------------
  logic [LANES-1:0] laneValid;
  logic [LANES-1:0] laneMinor;
  logic [LANES-1:0] laneReinit;
  logic [AW-1:0] wptrR [LANES];
  logic [AW-1:0] rptrR;
  logic relPulse;
  logic fillCaughtR;

  assign allValid = &laneValid;
  assign anyReinit = |laneReinit;
  assign relPulse = lmfcRun && allValid && !relR && (lmfcIdx == relIdx);

  // Common read pointer aligns all lanes to their first octet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relR <= 1'b0;
      rptrR <= '0;
      outValid <= 1'b0;
    end else if (coreRst || anyReinit) begin
      relR <= 1'b0;
      rptrR <= '0;
      outValid <= 1'b0;
    end else begin
      relR <= relR || relPulse;
      outValid <= relR || relPulse;
      if (relR || relPulse) begin
        rptrR <= rptrR + 1'b1;
      end
    end
  end

  // Fill is captured once per core reset so reads stay consistent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fillCaughtR <= 1'b0;
    end else if (coreRst) begin
      fillCaughtR <= 1'b0;
    end else if (relPulse) begin
      fillCaughtR <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Per lane buffer and error tracking
  // ----------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] posR;
    logic [7:0] frmR;
    logic [3:0] decR;
    logic [3:0] ctlR;
    logic [3:0] alnR;
    logic [7:0] posN;
    logic [7:0] frmN;
    logic [3:0] decN;
    logic [3:0] ctlN;
    logic [3:0] alnN;
    logic bad;
    logic endF;
    logic isCtl;
    logic minor;
    logic reinit;

    assign laneValid[g] = laneIn[g].valid;

    rxl_lane_ram #(.W(LANE_W), .DEPTH(BUF_DEPTH)) uRam (
      .clk(clk),
      .rst(rst),
      .wrEn(laneIn[g].valid),
      .wrAddr(wptrR[g]),
      .wrData(laneIn[g].data),
      .rdAddr(rptrR),
      .rdData(outData[g*LANE_W+:LANE_W])
    );

    // Lane writes from its own first valid word; skew shows in wptr
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        wptrR[g] <= '0;
      end else if (coreRst || anyReinit) begin
        wptrR[g] <= '0;
      end else if (laneIn[g].valid) begin
        wptrR[g] <= wptrR[g] + 1'b1;
      end
    end

    // Pointer difference in octets; read pointer is zero at release
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        fillR[g] <= '0;
      end else if (coreRst) begin
        fillR[g] <= '0;
      end else if (relPulse && !fillCaughtR) begin
        fillR[g] <= FILL_W'(wptrR[g]) << OCT_SHIFT;
      end
    end

    // Walk the four octets in order, tracking frame position
    always_comb begin
      posN = posR;
      frmN = frmR;
      decN = decR;
      ctlN = ctlR;
      alnN = alnR;
      bad = 1'b0;
      endF = 1'b0;
      isCtl = 1'b0;
      minor = 1'b0;
      reinit = 1'b0;
      for (int i = 0; i < OCT_PER_CYC; i++) begin
        bad = laneIn[g].dispErr[i] || laneIn[g].notInTable[i];
        endF = (posN == actF - 8'h01);
        isCtl = laneIn[g].isK[i] && !bad;
        decN = bad ? rxl_sat(decN) : 4'h0;
        if (isCtl && !endF) begin
          ctlN = rxl_sat(ctlN);
          minor = 1'b1;
        end else if (!bad) begin
          ctlN = 4'h0;
        end
        if (isCtl && laneIn[g].data[8*i+:8] == CHAR_MF_END) begin
          if (endF && frmN == 8'(actK) - 8'h01) begin
            alnN = 4'h0;
          end else begin
            alnN = rxl_sat(alnN);
            minor = 1'b1;
          end
        end
        if (decN >= LIM_DEC || ctlN >= LIM_CTL || alnN >= LIM_ALN) begin
          reinit = 1'b1;
        end
        if (endF) begin
          frmN = rxl_wrap(frmN, 8'(actK) - 8'h01);
        end
        posN = rxl_wrap(posN, actF - 8'h01);
      end
    end

    assign laneMinor[g] = laneIn[g].valid && minor;
    assign laneReinit[g] = laneIn[g].valid && reinit;

    // Counters restart with the lane; valid marks a frame start
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        posR <= '0;
        frmR <= '0;
        decR <= '0;
        ctlR <= '0;
        alnR <= '0;
      end else if (coreRst || anyReinit || !laneIn[g].valid) begin
        posR <= '0;
        frmR <= '0;
        decR <= '0;
        ctlR <= '0;
        alnR <= '0;
      end else begin
        posR <= posN;
        frmR <= frmN;
        decR <= decN;
        ctlR <= ctlN;
        alnR <= alnN;
      end
    end

    a_dec_four: assert property (@(posedge clk) disable iff (rst)
      laneIn[g].valid && laneIn[g].dispErr == ALL_OCT |-> laneReinit[g])
      else $error("four decode errors did not re-init");
    a_fill_held: assert property (@(posedge clk) disable iff (rst)
      fillCaughtR && !coreRst |=> $stable(fillR[g]))
      else $error("fill changed while held");
    a_fill_octets: assert property (@(posedge clk) disable iff (rst)
      relPulse && !fillCaughtR && !coreRst |=>
      fillR[g] == (FILL_W'($past(wptrR[g])) << OCT_SHIFT))
      else $error("fill not pointer difference");
  end

  // ----------------------------------------------------------
  // SYNC~ reporting
  // ----------------------------------------------------------
  rxl_sync_report uSync (
    .clk(clk),
    .rst(rst),
    .coreRst(coreRst),
    .frameOct(actF),
    .mfCycles(mfCycles),
    .lmfcIdx(lmfcIdx),
    .lmfcRun(lmfcRun),
    .errDis(ctrlR[CTRL_ERR_DIS]),
    .minorErr(|laneMinor),
    .reinitReq(anyReinit),
    .syncN(repSyncN),
    .longActive(longActive)
  );
  // Held low while the core is in reset so the link restarts
  assign syncN = repSyncN && !coreRst;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  logic [8:0] sinceSys;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceSys <= '0;
    end else if (!dlyAct && !lmfcRun && sysref) begin
      sinceSys <= '0;
    end else if (dlyAct) begin
      sinceSys <= sinceSys + 9'h001;
    end
  end

  a_boundary_shift: assert property (@(posedge clk) disable iff (rst || coreRst)
    $rose(lmfcRun) |-> sinceSys == 9'(actShift) + 9'h001)
    else $error("boundary shift wrong");
  a_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
    !coreRst |=> $stable(actTrim) && $stable(actShift))
    else $error("config moved outside reset");
  a_release_valid: assert property (@(posedge clk) disable iff (rst)
    $rose(relR) |-> $past(allValid) && outValid)
    else $error("released without all lanes");
  a_release_trim: assert property (@(posedge clk) disable iff (rst)
    $rose(relR) |-> $past(lmfcIdx) == $past(relIdx))
    else $error("release off trimmed boundary");
endmodule : rxl_rx_latency
`default_nettype wire

// [rxl_rx_latency_bench.sv]
`default_nettype none
module rxl_rx_latency_bench import rxl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, read, write, sysref, syncN, outValid, waitrequest, fell;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd, f0;
  logic [1:0] inj;
  logic [63:0] outData;
  rxl_lane_type lanes [2];
  int errTotal = 0;
  int cmpCount = 0;
  int lows;
  localparam logic [31:0] MF_OCT = 32'(FRM_F_RST_VAL) * 32'(FRM_K_RST_VAL);
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
  // ------
  // Design and far side
  // ------
  rxl_rx_latency #(.LANES(2)) uut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sysref(sysref), .laneIn(lanes), .syncN(syncN), .outData(outData), .outValid(outValid));
  rxl_tx_model far (.clk(clk), .rst(rst), .syncN(syncN), .inj(inj), .laneOut(lanes));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------
  // Shared tasks
  // ------
  // Request held until waitrequest seen low, then data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    // Only the watchdog ends a wait that never gets an answer
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // Core reset, one sysref, wait for release, read lane 0 fill
  task automatic link_up(input logic [31:0] sh);
    bus(1'b1, ADDR_SHIFT, sh);
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    @(posedge clk);
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
    do @(negedge clk); while (outValid !== 1'b1);
    `CHK("first word", 64'h1000000000000000, outData)
    bus(1'b0, ADDR_FILL0, 32'h0);
  endtask : link_up
  task automatic watch(input int cyc);
    lows = 0;
    fell = 1'b0;
    repeat (cyc) begin
      @(negedge clk);
      lows += (syncN !== 1'b1);
      fell |= (outValid === 1'b0);
    end
  endtask : watch
  task automatic inject(input logic [1:0] c);
    @(posedge clk);
    inj <= c;
    @(posedge clk);
    inj <= 2'h0;
  endtask : inject
  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    bus(1'b0, ADDR_FRAME, 32'h0);
    `CHK("frame", {19'h0, FRM_K_RST_VAL, FRM_F_RST_VAL}, rd)
    bus(1'b0, 8'hfc, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("t_regs done");
  endtask : t_regs
  // Fill figures, hold until core reset, boundary shift
  task automatic t_fill;
    link_up(32'h0);
    f0 = rd;
    `CHK("fill octets", 2'h0, rd[1:0])
    `CHK("fill width", 22'h0, rd[31:10])
    `CHK("fill set", 1'b1, rd[9:0] != 10'h0)
    `CHK("fill window", 1'b1, (f0 >= 32'h8) && (f0 <= MF_OCT - 32'h8))
    // One step of shift moves the fill by four octets
    link_up(32'h1);
    `CHK("fill shift", f0 + 32'h4, rd)
    bus(1'b0, ADDR_FILL0 + 8'h4, 32'h0);
    `CHK("fill lane1", f0 + 32'h4, rd)
    // Trim kept at smallest fill less the margin; no core reset follows
    bus(1'b1, ADDR_TRIM, rd - 32'h8);
    bus(1'b1, ADDR_SHIFT, 32'h2);
    bus(1'b0, ADDR_FILL0, 32'h0);
    `CHK("fill hold", f0 + 32'h4, rd)
    `CHK("out runs", 1'b1, outValid)
    $display("t_fill done");
  endtask : t_fill
  // One stray control octet, suppressed and then reported
  task automatic t_minor;
    for (int dis = 1; dis >= 0; dis--) begin
      bus(1'b1, ADDR_CTRL, 32'(dis) << CTRL_ERR_DIS);
      inject(2'h1);
      watch(24);
      `CHK("minor low", (dis == 1) ? 0 : MINOR_FRAMES * 2 / OCT_PER_CYC, lows)
    end
    $display("t_minor done");
  endtask : t_minor
  // Disparity then table errors force the long report
  task automatic t_reinit;
    for (int c = 2; c <= 3; c++) begin
      inject(2'(c));
      watch(40);
      `CHK("long low", REINIT_FRAMES * 2 / OCT_PER_CYC, lows)
      `CHK("out drop", 1'b1, fell)
    end
    $display("t_reinit done");
  endtask : t_reinit
  task automatic give_verdict;
    $display("checks %0d errors %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    give_verdict;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {read, write, sysref, address, writedata, inj} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_fill;
    t_minor;
    t_reinit;
    give_verdict;
  end
endmodule : rxl_rx_latency_bench
`default_nettype wire

// [rxl_sync_report.sv]
`default_nettype none
module rxl_sync_report import rxl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic coreRst,
  // Framing
  input wire logic [7:0] frameOct,
  input wire logic [10:0] mfCycles,
  input wire logic [10:0] lmfcIdx,
  input wire logic lmfcRun,
  // Error events
  input wire logic errDis,
  input wire logic minorErr,
  input wire logic reinitReq,
  // Status
  output logic syncN,
  output logic longActive
);
  typedef enum logic [1:0] {SY_IDLE, SY_MINOR, SY_LONG} rxl_sync_type;

  rxl_sync_type stR;
  logic [10:0] cntR;
  logic pendR;
  logic [10:0] minorLen;
  logic [10:0] longLen;
  logic startMinor;
  logic enterLong;

  // ----------------------------------------------------------
  // Pulse lengths in core cycles
  // ----------------------------------------------------------
  // Two frames rounds up so short frames still give one cycle
  assign minorLen = 11'((MINOR_FRAMES * int'(frameOct) + OCT_PER_CYC - 1) / OCT_PER_CYC);
  assign longLen = 11'((REINIT_FRAMES * int'(frameOct)) / OCT_PER_CYC);
  assign startMinor = (stR == SY_IDLE) && pendR && lmfcRun
    && (lmfcIdx == mfCycles - minorLen);
  assign enterLong = reinitReq && (stR != SY_LONG);

  // Pending minor error, set wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendR <= 1'b0;
    end else if (coreRst) begin
      pendR <= 1'b0;
    end else begin
      pendR <= ((pendR && !startMinor) || minorErr) && !errDis;
    end
  end

  // Line state; a re-init request overrides a minor pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stR <= SY_IDLE;
      cntR <= '0;
    end else if (coreRst) begin
      stR <= SY_IDLE;
      cntR <= '0;
    end else if (enterLong) begin
      stR <= SY_LONG;
      cntR <= longLen - 11'h001;
    end else begin
      unique case (stR)
        SY_IDLE: begin
          if (startMinor) begin
            stR <= SY_MINOR;
            cntR <= minorLen - 11'h001;
          end
        end
        SY_MINOR, SY_LONG: begin
          if (cntR == '0) begin
            stR <= SY_IDLE;
          end else begin
            cntR <= cntR - 11'h001;
          end
        end
      endcase
    end
  end

  assign syncN = (stR == SY_IDLE);
  assign longActive = (stR == SY_LONG);

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  logic [10:0] lowCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt <= '0;
    end else if (syncN || enterLong) begin
      lowCnt <= '0;
    end else begin
      lowCnt <= lowCnt + 11'h001;
    end
  end

  sequence s_minor_begin;
    stR == SY_IDLE ##1 stR == SY_MINOR;
  endsequence

  a_minor_gate: assert property (@(posedge clk) disable iff (rst)
    errDis && !pendR |=> !pendR) else $error("pending set while disabled");
  a_minor_end: assert property (@(posedge clk) disable iff (rst || coreRst)
    s_minor_begin |-> $past(lmfcIdx) == $past(mfCycles) - $past(minorLen))
    else $error("minor pulse off the multiframe end");
  a_minor_len: assert property (@(posedge clk) disable iff (rst || coreRst)
    $rose(syncN) && $past(stR) == SY_MINOR |-> lowCnt == minorLen)
    else $error("minor pulse length wrong");
  a_long_len: assert property (@(posedge clk) disable iff (rst || coreRst)
    $rose(syncN) && $past(stR) == SY_LONG |-> lowCnt == longLen)
    else $error("re-init pulse length wrong");
  a_long_prio: assert property (@(posedge clk) disable iff (rst || coreRst)
    reinitReq |=> !syncN ##1 !syncN) else $error("re-init not reported");
endmodule : rxl_sync_report
`default_nettype wire

// [rxl_tx_model.sv]
`default_nettype none
module rxl_tx_model import rxl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic syncN,
  input wire logic [1:0] inj,
  output rxl_lane_type laneOut [2]
);
  logic [27:0] cnt_r;
  initial laneOut = '{default: '0};
  // Word count restarts whenever SYNC~ is low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= syncN ? cnt_r + 28'h1 : '0;
    end
  end
  // SYNC~ taken as whole cycles; two-octet frames need no half pulse
  // Idle lanes toggle their data so stale words never look valid
  always @(posedge clk) begin
    for (int g = 0; g < 2; g++) begin
      laneOut[g].valid <= syncN && !rst;
      laneOut[g].data <= syncN ? {4'(g), cnt_r} : ~laneOut[g].data;
      laneOut[g].isK <= (g == 0 && inj == 2'h1) ? 4'h1 : 4'h0;
      laneOut[g].dispErr <= (g == 0 && inj == 2'h2) ? 4'hf : 4'h0;
      laneOut[g].notInTable <= (g == 0 && inj == 2'h3) ? 4'hf : 4'h0;
    end
  end
endmodule : rxl_tx_model
`default_nettype wire
